// ---- design/rtcca_cfg.svh ----
// rtc clock/control access: constants
`ifndef RTCCA_CFG_SVH
`define RTCCA_CFG_SVH
`define RTCCA_SLAVE_ID  7'h6f
`define RTCCA_ACK_BIT   4'h8
`define RTCCA_ACK_END   4'h9
`define RTCCA_DIV_MAX   15'h7fff
`define RTCCA_DIV_HALF  15'h4000
`define RTCCA_DIV_4K    2
`define RTCCA_DIV_1HZ   14
`define RTCCA_CTRL_LAST 3'h4
`define RTCCA_SR_IDX    3'h7
`define RTCCA_SR_WEL    8'h02
`define RTCCA_SR_REGISTER_WRITE_ENABLE_LATCH   8'h06
`define RTCCA_SR_CLR    8'h00
`define RTCCA_INT_IDX   5'h11
`define RTCCA_INT_RST   8'h08
`define RTCCA_PWR_IDX   5'h14
`define RTCCA_PWR_RST   8'h40
`define RTCCA_IM_BIT    7
`define RTCCA_ALE_LSB   5
`define RTCCA_FO_LSB    3
`define RTCCA_FO_IRQ    2'h0
`define RTCCA_FO_32K    2'h1
`define RTCCA_FO_4K     2'h2
`define RTCCA_FO_1HZ    2'h3
`define RTCCA_ALM_CMP   7
`define RTCCA_TIME_CNT  7
`define RTCCA_T_SEC     3'h0
`define RTCCA_T_MIN     3'h1
`define RTCCA_T_HR      3'h2
`define RTCCA_T_DT      3'h3
`define RTCCA_T_MO      3'h4
`define RTCCA_T_YR      3'h5
`define RTCCA_T_DW      3'h6
`define RTCCA_T_Y2K     3'h7
`define RTCCA_DT_RST    8'h01
`define RTCCA_Y2K_RST   8'h20
`define RTCCA_BCD_NINE  4'h9
`define RTCCA_BCD_59    8'h59
`define RTCCA_BCD_99    8'h99
`define RTCCA_HR_23     6'h23
`define RTCCA_HR_11     5'h11
`define RTCCA_HR_12     5'h12
`define RTCCA_HR_24_RST 8'h80
`define RTCCA_DOW_LAST  8'h06
`define RTCCA_ONE       8'h01
`define RTCCA_DEC       8'h12
`define RTCCA_FEB       8'h02
`define RTCCA_APR       8'h04
`define RTCCA_JUN       8'h06
`define RTCCA_SEP       8'h09
`define RTCCA_NOV       8'h11
`define RTCCA_D28       8'h28
`define RTCCA_D29       8'h29
`define RTCCA_D30       8'h30
`define RTCCA_D31       8'h31
`define RTCCA_APB_CTRL  8'h00
`define RTCCA_APB_STAT  8'h04
`endif

// ---- design/rtcca_pkg.sv ----
// rtc clock/control access: shared types
package rtcca_pkg;
  typedef enum logic [2:0] {st_idle, st_slave, st_ahi, st_alo, st_wr, st_rd, st_halt} rtcca_state_e;
  typedef enum logic [2:0] {sec_alm0, sec_alm1, sec_ctrl, sec_id, sec_time, sec_stat,
                            sec_none} rtcca_sect_e;
endpackage

// ---- design/rtcca_core.sv ----
// rtc clock/control core with serial access and apb side registers
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "rtcca_cfg.svh"
module rtcca_core #(
  parameter logic [63:0] ID_VALUE = 64'h5a5a_0f0f_3c3c_9696 // arbitrary value
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // crystal timebase
  input  wire logic        xtal_in,
  // alarm_or_freq_pin, open drain
  output logic             alarm_or_freq_pin_out,
  output logic             alarm_or_freq_pin_oe
);
  rtcca_pkg::rtcca_state_e state;
  rtcca_pkg::rtcca_sect_e  op_sect;
  logic        scl_q1, scl_q2, scl_q3, sda_q1, sda_q2, sda_q3;
  logic        xtal_q1, xtal_q2, xtal_q3;
  logic        scl_rise, scl_fall, bus_start, bus_stop, xtal_edge;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg, obyte, rd_now, sr_byte;
  logic [15:0] ptr;
  logic        rd_first, wr_ok, write_enable_latch, register_write_enable_latch, cff, on_batt, pend;
  logic [7:0]  stg_mask;
  logic [7:0]  stg [0:7];
  logic [7:0]  tm [0:7];
  logic [7:0]  tnew [0:7];
  logic [7:0]  hold [0:7];
  logic [7:0]  next_tm [0:7];
  logic [7:0]  nvm [0:23];
  logic        day_end;
  logic [14:0] div;
  logic        tick, tick_d, pulse_act;
  logic [1:0]  al, al_snap, al_clr, hit, ale;
  logic        commit;

  function automatic rtcca_pkg::rtcca_sect_e sect_of(input logic [15:0] a);
    sect_of = rtcca_pkg::sec_none;
    if (a[15:6] == 10'h000)
    begin
      case (a[5:3])
        3'h0: sect_of = rtcca_pkg::sec_alm0;
        3'h1: sect_of = rtcca_pkg::sec_alm1;
        3'h2: sect_of = (a[2:0] <= `RTCCA_CTRL_LAST) ? rtcca_pkg::sec_ctrl : rtcca_pkg::sec_none;
        3'h4: sect_of = rtcca_pkg::sec_id;
        3'h6: sect_of = rtcca_pkg::sec_time;
        3'h7: sect_of = (a[2:0] == `RTCCA_SR_IDX) ? rtcca_pkg::sec_stat : rtcca_pkg::sec_none;
        default: sect_of = rtcca_pkg::sec_none;
      endcase
    end
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == `RTCCA_BCD_NINE) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // last date of a month; years divisible by four are leap up to 2099
  function automatic logic [7:0] month_end(input logic [7:0] mo, input logic [7:0] yr);
    if (mo == `RTCCA_FEB)
      month_end = (!yr[0] && (yr[1] == yr[4])) ? `RTCCA_D29 : `RTCCA_D28;
    else if (mo == `RTCCA_APR || mo == `RTCCA_JUN || mo == `RTCCA_SEP || mo == `RTCCA_NOV)
      month_end = `RTCCA_D30;
    else
      month_end = `RTCCA_D31;
  endfunction

  // alarm byte bit 7 enables its field; at least one field must be enabled
  function automatic logic alm_match(input logic a);
    logic any;
    logic ok;
    any = 1'b0;
    ok  = 1'b1;
    for (int k = 0; k < `RTCCA_ALM_CMP; k++)
    begin
      if (nvm[{1'b0, a, k[2:0]}][7])
      begin
        any = 1'b1;
        if (nvm[{1'b0, a, k[2:0]}][6:0] != tm[k][6:0])
          ok = 1'b0;
      end
    end
    alm_match = any && ok;
  endfunction

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {scl_q1, scl_q2, scl_q3} <= 3'h7;
      {sda_q1, sda_q2, sda_q3} <= 3'h7;
      {xtal_q1, xtal_q2, xtal_q3} <= 3'h0;
    end
    else
    begin
      {scl_q1, scl_q2, scl_q3} <= {scl_in, scl_q1, scl_q2};
      {sda_q1, sda_q2, sda_q3} <= {sda_in, sda_q1, sda_q2};
      {xtal_q1, xtal_q2, xtal_q3} <= {xtal_in, xtal_q1, xtal_q2};
    end
  end

  assign scl_rise  = scl_q2 && !scl_q3;
  assign scl_fall  = !scl_q2 && scl_q3;
  assign bus_start = scl_q2 && scl_q3 && !sda_q2 && sda_q3;
  assign bus_stop  = scl_q2 && scl_q3 && sda_q2 && !sda_q3;
  assign xtal_edge = xtal_q2 && !xtal_q3;
  assign sr_byte   = {on_batt, al, 2'b00, register_write_enable_latch, write_enable_latch, cff};
  assign commit    = bus_stop && wr_ok;
  assign ale       = nvm[`RTCCA_INT_IDX][`RTCCA_ALE_LSB +: 2];

  always_comb
  begin
    rd_now = 8'h00;
    case (sect_of(ptr))
      rtcca_pkg::sec_alm0, rtcca_pkg::sec_alm1, rtcca_pkg::sec_ctrl: rd_now = nvm[ptr[4:0]];
      rtcca_pkg::sec_id:   rd_now = ID_VALUE[{ptr[2:0], 3'b000} +: 8];
      rtcca_pkg::sec_time: rd_now = rd_first ? tm[ptr[2:0]] : hold[ptr[2:0]];
      rtcca_pkg::sec_stat: rd_now = sr_byte;
      default:             rd_now = 8'h00;
    endcase
  end

  // serial slave engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= rtcca_pkg::st_idle;
      op_sect  <= rtcca_pkg::sec_none;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      obyte    <= 8'h00;
      ptr      <= 16'h0000;
      rd_first <= 1'b0;
      wr_ok    <= 1'b0;
      stg_mask <= 8'h00;
      sda_oe   <= 1'b0;
      al_snap  <= 2'b00;
      al_clr   <= 2'b00;
      for (int i = 0; i < 8; i++)
      begin
        stg[i]  <= 8'h00;
        hold[i] <= 8'h00;
      end
    end
    else
    begin
      al_clr <= 2'b00;
      if (bus_start)
      begin
        state  <= rtcca_pkg::st_slave;
        bitcnt <= 4'h0;
        wr_ok  <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state  <= rtcca_pkg::st_idle;
        wr_ok  <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (bitcnt < `RTCCA_ACK_BIT)
          shreg <= {shreg[6:0], sda_q2};
        if (bitcnt == `RTCCA_ACK_BIT && state == rtcca_pkg::st_rd && sda_q2)
          state <= rtcca_pkg::st_halt;
        bitcnt <= bitcnt + 4'h1;
      end
      else if (scl_fall && bitcnt == `RTCCA_ACK_BIT)
      begin
        unique case (state)
          rtcca_pkg::st_slave:
          begin
            if (shreg[7:1] == `RTCCA_SLAVE_ID)
            begin
              sda_oe <= 1'b1;
              if (shreg[0])
              begin
                state    <= rtcca_pkg::st_rd;
                rd_first <= 1'b1;
              end
              else
                state <= rtcca_pkg::st_ahi;
            end
            else
              state <= rtcca_pkg::st_idle;
          end
          rtcca_pkg::st_ahi:
          begin
            ptr[15:8] <= shreg;
            sda_oe    <= 1'b1;
            state     <= rtcca_pkg::st_alo;
          end
          rtcca_pkg::st_alo:
          begin
            ptr[7:0] <= shreg;
            op_sect  <= sect_of({ptr[15:8], shreg});
            stg      <= tm;
            stg_mask <= 8'h00;
            sda_oe   <= 1'b1;
            state    <= rtcca_pkg::st_wr;
          end
          rtcca_pkg::st_wr:
          begin
            // leaving the section refuses the byte; latches do not gate the ack
            if (sect_of(ptr) == op_sect && op_sect != rtcca_pkg::sec_none)
            begin
              sda_oe             <= 1'b1;
              stg[ptr[2:0]]      <= shreg;
              stg_mask[ptr[2:0]] <= 1'b1;
              wr_ok              <= 1'b1;
              ptr                <= ptr + 16'h0001;
            end
            else
              state <= rtcca_pkg::st_halt;
          end
          rtcca_pkg::st_rd:
          begin
            sda_oe <= 1'b0;
            if (op_sect == rtcca_pkg::sec_stat)
              al_clr <= al_snap;
          end
          rtcca_pkg::st_idle, rtcca_pkg::st_halt:
            sda_oe <= 1'b0;
          default:
            state <= rtcca_pkg::st_idle;
        endcase
      end
      else if (scl_fall && bitcnt == `RTCCA_ACK_END)
      begin
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        if (state == rtcca_pkg::st_rd)
        begin
          if (!rd_first && (sect_of(ptr) != op_sect || op_sect == rtcca_pkg::sec_stat))
            state <= rtcca_pkg::st_halt;
          else
          begin
            rd_first <= 1'b0;
            if (rd_first)
            begin
              hold    <= tm;
              op_sect <= sect_of(ptr);
            end
            obyte   <= rd_now;
            sda_oe  <= !rd_now[7];
            al_snap <= al;
            ptr     <= ptr + 16'h0001;
          end
        end
      end
      else if (scl_fall && state == rtcca_pkg::st_rd && bitcnt < `RTCCA_ACK_BIT)
        sda_oe <= !obyte[~bitcnt[2:0]];
    end
  end

  // status latches and clock fail flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_enable_latch  <= 1'b0;
      register_write_enable_latch <= 1'b0;
      cff  <= 1'b1;
    end
    else if (commit)
    begin
      if (op_sect == rtcca_pkg::sec_stat)
      begin
        if (stg[`RTCCA_SR_IDX] == `RTCCA_SR_CLR)
        begin
          write_enable_latch  <= 1'b0;
          register_write_enable_latch <= 1'b0;
        end
        else if (stg[`RTCCA_SR_IDX] == `RTCCA_SR_WEL)
        begin
          write_enable_latch  <= 1'b1;
          register_write_enable_latch <= 1'b0;
        end
        else if (stg[`RTCCA_SR_IDX] == `RTCCA_SR_REGISTER_WRITE_ENABLE_LATCH && write_enable_latch)
          register_write_enable_latch <= 1'b1;
      end
      if (op_sect == rtcca_pkg::sec_time && write_enable_latch && register_write_enable_latch)
        cff <= 1'b0;
    end
  end

  // stored alarm and control bytes, written only on a valid stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 24; i++)
        nvm[i] <= 8'h00;
      nvm[`RTCCA_INT_IDX] <= `RTCCA_INT_RST;
      nvm[`RTCCA_PWR_IDX] <= `RTCCA_PWR_RST;
    end
    else if (commit && write_enable_latch && register_write_enable_latch && (op_sect == rtcca_pkg::sec_alm0 ||
             op_sect == rtcca_pkg::sec_alm1 || op_sect == rtcca_pkg::sec_ctrl))
    begin
      for (int i = 0; i < 8; i++)
        if (stg_mask[i])
          nvm[{ptr[4:3], i[2:0]}] <= stg[i];
    end
  end

  // next calendar value in bcd
  always_comb
  begin
    next_tm = tm;
    day_end = 1'b0;
    if (tm[`RTCCA_T_SEC] == `RTCCA_BCD_59)
    begin
      next_tm[`RTCCA_T_SEC] = 8'h00;
      if (tm[`RTCCA_T_MIN] == `RTCCA_BCD_59)
      begin
        next_tm[`RTCCA_T_MIN] = 8'h00;
        if (tm[`RTCCA_T_HR][7])
        begin
          day_end = (tm[`RTCCA_T_HR][5:0] == `RTCCA_HR_23);
          next_tm[`RTCCA_T_HR] = day_end ? `RTCCA_HR_24_RST : bcd_inc(tm[`RTCCA_T_HR]);
        end
        else if (tm[`RTCCA_T_HR][4:0] == `RTCCA_HR_11)
        begin
          day_end = tm[`RTCCA_T_HR][5];
          next_tm[`RTCCA_T_HR] = {2'b00, !tm[`RTCCA_T_HR][5], `RTCCA_HR_12};
        end
        else if (tm[`RTCCA_T_HR][4:0] == `RTCCA_HR_12)
          next_tm[`RTCCA_T_HR] = {2'b00, tm[`RTCCA_T_HR][5], 5'h01};
        else
          next_tm[`RTCCA_T_HR] = bcd_inc(tm[`RTCCA_T_HR]);
      end
      else
        next_tm[`RTCCA_T_MIN] = bcd_inc(tm[`RTCCA_T_MIN]);
    end
    else
      next_tm[`RTCCA_T_SEC] = bcd_inc(tm[`RTCCA_T_SEC]);
    if (day_end)
    begin
      next_tm[`RTCCA_T_DW] = (tm[`RTCCA_T_DW] == `RTCCA_DOW_LAST) ? 8'h00 :
                             tm[`RTCCA_T_DW] + 8'h01;
      if (tm[`RTCCA_T_DT] == month_end(tm[`RTCCA_T_MO], tm[`RTCCA_T_YR]))
      begin
        next_tm[`RTCCA_T_DT] = `RTCCA_ONE;
        if (tm[`RTCCA_T_MO] == `RTCCA_DEC)
        begin
          next_tm[`RTCCA_T_MO] = `RTCCA_ONE;
          next_tm[`RTCCA_T_YR] = (tm[`RTCCA_T_YR] == `RTCCA_BCD_99) ? 8'h00 :
                                 bcd_inc(tm[`RTCCA_T_YR]);
        end
        else
          next_tm[`RTCCA_T_MO] = bcd_inc(tm[`RTCCA_T_MO]);
      end
      else
        next_tm[`RTCCA_T_DT] = bcd_inc(tm[`RTCCA_T_DT]);
    end
  end

  // time counters; a pending write replaces the count at the next tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        tm[i]   <= 8'h00;
        tnew[i] <= 8'h00;
      end
      tm[`RTCCA_T_DT]  <= `RTCCA_DT_RST;
      tm[`RTCCA_T_Y2K] <= `RTCCA_Y2K_RST;
    end
    else
    begin
      if (tick)
      begin
        if (pend)
        begin
          pend <= 1'b0;
          for (int i = 0; i < `RTCCA_TIME_CNT; i++)
            tm[i] <= tnew[i];
        end
        else if (!cff)
          tm <= next_tm;
      end
      if (commit && op_sect == rtcca_pkg::sec_time && write_enable_latch && register_write_enable_latch)
      begin
        tnew <= stg;
        pend <= 1'b1;
      end
    end
  end

  // crystal divider, alarm flags and pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div       <= 15'h0000;
      tick      <= 1'b0;
      tick_d    <= 1'b0;
      al        <= 2'b00;
      pulse_act <= 1'b0;
    end
    else
    begin
      if (xtal_edge)
        div <= div + 15'h0001;
      tick   <= xtal_edge && div == `RTCCA_DIV_MAX;
      tick_d <= tick;
      al     <= (al & ~al_clr) | (tick_d ? hit : 2'b00);
      if (tick_d && |(hit & ale))
        pulse_act <= 1'b1;
      else if (xtal_edge && div == `RTCCA_DIV_HALF)
        pulse_act <= 1'b0;
    end
  end

  assign hit = {alm_match(1'b1), alm_match(1'b0)};

  // shared output pin, open drain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_or_freq_pin_out <= 1'b0;
      alarm_or_freq_pin_oe  <= 1'b0;
      sda_out               <= 1'b0;
    end
    else
    begin
      alarm_or_freq_pin_out <= 1'b0;
      sda_out               <= 1'b0;
      unique case (nvm[`RTCCA_INT_IDX][`RTCCA_FO_LSB +: 2])
        `RTCCA_FO_IRQ: alarm_or_freq_pin_oe <= nvm[`RTCCA_INT_IDX][`RTCCA_IM_BIT] ?
                                               pulse_act : |(al & ale);
        `RTCCA_FO_32K: alarm_or_freq_pin_oe <= !xtal_q2;
        `RTCCA_FO_4K:  alarm_or_freq_pin_oe <= !div[`RTCCA_DIV_4K];
        `RTCCA_FO_1HZ: alarm_or_freq_pin_oe <= !div[`RTCCA_DIV_1HZ];
      endcase
    end
  end

  // apb side registers, zero wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      on_batt <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (psel && !penable)
      begin
        pslverr <= !(paddr == `RTCCA_APB_CTRL || paddr == `RTCCA_APB_STAT);
        if (paddr == `RTCCA_APB_CTRL)
          prdata <= {31'h0000_0000, on_batt};
        else if (paddr == `RTCCA_APB_STAT)
          prdata <= {tm[`RTCCA_T_HR], tm[`RTCCA_T_MIN], tm[`RTCCA_T_SEC], sr_byte};
        else
          prdata <= 32'h0000_0000;
      end
      else if (!psel)
        pslverr <= 1'b0;
      if (psel && penable && pwrite && paddr == `RTCCA_APB_CTRL)
        on_batt <= pwdata[0];
    end
  end
endmodule // rtcca_core

// ---- verification/rtcca_chk_assertions.sv ----
// port checker for the rtc clock/control core
`timescale 1ns/1ps
module rtcca_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        alarm_or_freq_pin_out,
  input wire logic        alarm_or_freq_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic hit = paddr == 8'h00 || paddr == 8'h04;
  a_ready_up: assert property ($past(presetn) |-> pready)
    else $error("pready low out of reset");
  a_err_unmapped: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (acc && hit |-> !pslverr)
    else $error("mapped access flagged");
  a_err_drop: assert property (!psel |=> !pslverr)
    else $error("error held while idle");
  a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_open_drain: assert property (!sda_out && !alarm_or_freq_pin_out)
    else $error("pin driven high");
  a_stat_zero: assert property (acc && !pwrite && paddr == 8'h04 |-> prdata[4:3] == 2'b00)
    else $error("unused status bits set");
  a_reset_quiet: assert property ($rose(presetn) |-> !sda_oe && !alarm_or_freq_pin_oe)
    else $error("pins pulled right after reset");
endmodule // rtcca_chk
bind rtcca_core rtcca_chk u_chk (.*);

// ---- verification/rtcca_host.sv ----
// host model: two-wire bus master that makes the serial clock
`timescale 1ns/1ps
module rtcca_host (
  // clock
  input  wire logic pclk,
  // bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // start or repeated start
  task automatic s();
    sda_oe <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b1;
    w(4);
    scl <= 1'b0;
  endtask
  task automatic bit_io(input logic d, output logic r);
    sda_oe <= !d;
    w(4);
    scl <= 1'b1;
    w(4);
    r = sda;
    scl <= 1'b0;
  endtask
  // eight bits msb first, then the ninth (ack) bit
  task automatic x(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask
  task automatic p();
    sda_oe <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b0;
    w(4);
  endtask
endmodule // rtcca_host

// ---- verification/rtc_clock_control_access_tb.sv ----
// bench for the rtc clock/control core
`timescale 1ns/1ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t %s", $time, m); end end
module rtc_clock_control_access_tb;
  localparam logic [63:0] IDV = 64'h3c5a_9612_e07b_4d81; // arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, xtal_in, scl, h_oe, e, ak;
  logic        pready, pslverr, sda_out, sda_oe, pin_out, pin_oe;
  logic [7:0]  paddr, b, bq[$];
  logic [31:0] pwdata, prdata, q;
  logic        aq[$];
  int          n_errors, cmp_count, seed, k;
  wire logic   sda = !(sda_oe || h_oe);
  rtcca_host host (.pclk(pclk), .sda(sda), .scl(scl), .sda_oe(h_oe));
  rtcca_core #(.ID_VALUE(IDV)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .xtal_in(xtal_in), .alarm_or_freq_pin_out(pin_out),
    .alarm_or_freq_pin_oe(pin_oe));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = !pclk;
  end
  // fast crystal stand-in so pin rates show in a short window
  initial begin
    xtal_in = 1'b0;
    forever begin repeat (6) @(posedge pclk); xtal_in <= !xtal_in; end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end
  // psel stays up for back-to-back use; caller drops it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    penable <= 1'b0;
  endtask
  task automatic hdr(input logic [7:0] a);
    host.s();
    host.x(8'hde, 1'b1, b, ak);
    host.x(8'h00, 1'b1, b, ak);
    host.x(a, 1'b1, b, ak);
  endtask
  task automatic sw(input logic [7:0] a);
    aq = {};
    hdr(a);
    foreach (bq[i]) begin host.x(bq[i], 1'b1, b, ak); aq.push_back(ak); end
    host.p();
  endtask
  task automatic rd(input int n);
    host.s();
    host.x(8'hdf, 1'b1, b, ak);
    for (int i = 0; i < n; i++) begin host.x(8'hff, i == n - 1, b, ak); bq.push_back(b); end
    host.p();
  endtask
  task automatic sr(input logic [7:0] a, input int n);
    hdr(a);
    bq = {};
    rd(n);
  endtask
  task automatic pin_cnt();
    logic v;
    k = 0;
    v = pin_oe;
    repeat (400) begin @(posedge pclk); if (pin_oe !== v) k++; v = pin_oe; end
  endtask
  // pin edges expected in 400 cycles for each output code
  function automatic int fexp(input logic [1:0] fo);
    case (fo)
      2'h1: return 400 / 6;
      2'h2: return 400 / 48;
      default: return 0;
    endcase
  endfunction
  initial begin
    seed = 98;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK(q, 32'h0000_0001, "stat reset")
    for (int i = 0; i < 6; i++) begin
      b = $random(seed);
      if (b == 8'h00 || b == 8'h04) b = 8'h3c;
      apb(i[0], b, $random(seed));
      `CHK(e, 1'b1, "unmapped")
      apb(1'b1, 8'h04, $random(seed));
    end
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK({e, q}, 33'h0_0000_0001, "stat kept")
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK(q, 32'h0000_0001, "battery bit")
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK(q[7:0], 8'h81, "battery in status")
    apb(1'b1, 8'h00, 32'h0000_0000);
    psel <= 1'b0;
    $display("apb test done");
    host.s();
    host.x(8'hd0, 1'b1, b, ak);
    host.p();
    `CHK(ak, 1'b1, "foreign id acked")
    bq = '{8'h18};
    sw(8'h11);
    `CHK(aq[0], 1'b0, "locked nack")
    sr(8'h11, 1);
    `CHK(bq[0], 8'h08, "locked write took")
    bq = '{8'h02};
    sw(8'h3f);
    bq = '{8'h02, 8'h00};
    sw(8'h3f);
    `CHK(aq[1], 1'b1, "status run-on")
    sr(8'h3f, 1);
    `CHK(bq[0], 8'h03, "wel")
    bq = '{8'h06};
    sw(8'h3f);
    sr(8'h3f, 1);
    `CHK(bq[0], 8'h07, "register_write_enable_latch")
    hdr(8'h11);
    host.x(8'h18, 1'b1, b, ak);
    sr(8'h11, 1);
    `CHK(bq[0], 8'h08, "aborted write took")
    for (int i = 1; i < 5; i++) begin
      bq = '{{3'b000, i[1:0], 3'b000}};
      sw(8'h11);
      sr(8'h11, 1);
      `CHK(bq[0], {3'b000, i[1:0], 3'b000}, "ctrl byte")
      pin_cnt();
      `CHK(k inside {[fexp(i[1:0]) - 1 : fexp(i[1:0]) + 1]}, 1'b1, "pin rate")
    end
    bq = '{8'h40, 8'h55};
    sw(8'h14);
    `CHK(aq[1], 1'b1, "section run-on")
    $display("serial control test done");
    bq = {};
    repeat (8) bq.push_back($random(seed));
    sw(8'h20);
    sr(8'h20, 8);
    foreach (bq[i]) `CHK(bq[i], IDV[8*i +: 8], "id byte")
    sr(8'h26, 3);
    `CHK({bq[0], bq[1], bq[2]}, {IDV[55:48], IDV[63:56], 8'hff}, "id edge")
    sr(8'h21, 1);
    bq = {};
    rd(1);
    `CHK(bq[0], IDV[23:16], "next address")
    bq = '{8'h45, 8'h59, 8'ha3, 8'h31, 8'h12, 8'h99, 8'h06, 8'h20};
    sw(8'h30);
    foreach (aq[i]) `CHK(aq[i], 1'b0, "time ack")
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK(q[31:8], 24'h00_0000, "time early")
    `CHK(q[7:0], 8'h06, "fail flag cleared")
    psel <= 1'b0;
    $display("id and time test done");
    tally_and_finish();
  end
endmodule // rtc_clock_control_access_tb
